/* File: clch_top.sv */
// Purpose: latch capture, compare outputs, hysteresis and process event bits
// Assumes: counter core on the same clock, latch and input pins asynchronous
// Notes:   registers reached over a plain one-cycle strobe port
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module clch_top
  import clch_pkg::*;
#(
  parameter int NCH      = CLCH_NCH,
  parameter int NDIN     = CLCH_NDIN,
  parameter int STEP_CYC = CLCH_STEP_CYC
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // register port
  input  wire logic [CLCH_AW-1:0]    addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [31:0]           rdata,
  // counter core
  input  wire clch_cnt_t [NCH-1:0]   cnt_in,
  // pins
  input  wire logic [NCH-1:0]        latch_pin,
  input  wire logic [NDIN-1:0]       din_pin,
  // outputs
  output logic      [NCH-1:0]        cmp_out,
  output logic                       process_irq
);

  // ==========================================================================
  // storage
  clch_cfg_t [NCH-1:0]   cfg_r;
  logic      [31:0]      cmp_r      [NCH];
  logic      [15:0]      outsts_r   [NCH];
  logic      [31:0]      latch_r    [NCH];
  logic      [NCH-1:0]   new_latch_r;
  logic      [NCH-1:0]   overflow_status_flag_r;
  logic      [NCH-1:0]   underflow_status_flag_r;
  logic      [31:0]      event_r;
  logic      [31:0]      event_nxt;
  logic                  irqen_in_r;
  logic      [31:0]      rdata_r;
  logic                  process_irq_r;

  // pin synchronisers
  logic [NCH-1:0]  latch_s1_r;
  logic [NCH-1:0]  latch_s2_r;
  logic [NCH-1:0]  latch_p_r;
  logic [NDIN-1:0] din_s1_r;
  logic [NDIN-1:0] din_s2_r;
  logic [NDIN-1:0] din_p_r;

  // channel results
  logic [NCH-1:0] reach;
  logic [NCH-1:0] hyst_on;
  logic [NCH-1:0] unit_out;

  // decode
  logic                 ch_hit;
  logic [1:0]           ch_sel;
  logic [7:0]           ch_ofs;
  logic [NCH-1:0]       wr_outsts;
  logic [NCH-1:0]       wr_insts;

  assign ch_hit = (addr[7] == 1'b0);
  assign ch_sel = addr[CLCH_CH_STRIDE_LSB+1:CLCH_CH_STRIDE_LSB];
  assign ch_ofs = {3'h0, addr[CLCH_CH_STRIDE_LSB-1:0]};

  // ==========================================================================
  // channel units
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    clch_unit #(
      .STEP_CYC (STEP_CYC)
    ) u_unit (
      .clock    (clock),
      .resetn   (resetn),
      .cfg      (cfg_r[g]),
      .cmp_val  (cmp_r[g]),
      .cnt      (cnt_in[g]),
      .out_q    (unit_out[g]),
      .reach_q  (reach[g]),
      .hyst_on  (hyst_on[g])
    );
    assign wr_outsts[g] = wr && ch_hit && (ch_sel == 2'(g)) && (ch_ofs == CLCH_OFS_OUTSTS);
    assign wr_insts[g]  = wr && ch_hit && (ch_sel == 2'(g)) && (ch_ofs == CLCH_OFS_INSTS);
  end

  assign cmp_out     = unit_out;
  assign rdata       = rdata_r;
  assign process_irq = process_irq_r;

  // ==========================================================================
  // synchronisers
  // two stages before any edge detector; first stage read by second only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latch_s1_r <= '0;
      latch_s2_r <= '0;
      latch_p_r  <= '0;
      din_s1_r   <= '0;
      din_s2_r   <= '0;
      din_p_r    <= '0;
    end else begin
      latch_s1_r <= latch_pin;
      latch_s2_r <= latch_s1_r;
      latch_p_r  <= latch_s2_r;
      din_s1_r   <= din_pin;
      din_s2_r   <= din_s1_r;
      din_p_r    <= din_s2_r;
    end
  end

  // ==========================================================================
  // configuration writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_r[i]    <= clch_cfg_t'(CLCH_CFG_RST);
        cmp_r[i]    <= CLCH_CMP_RST;
        outsts_r[i] <= CLCH_OUTSTS_RST;
      end
      irqen_in_r <= 1'b0;
    end else if (wr) begin
      if (ch_hit && ch_ofs == CLCH_OFS_CFG) begin
        cfg_r[ch_sel] <= clch_cfg_t'(wdata[23:0]);
      end else if (ch_hit && ch_ofs == CLCH_OFS_CMP) begin
        cmp_r[ch_sel] <= wdata;
      end else if (ch_hit && ch_ofs == CLCH_OFS_OUTSTS) begin
        outsts_r[ch_sel] <= wdata[15:0];
      end else if (!ch_hit && addr == CLCH_OFS_IRQEN) begin
        irqen_in_r <= wdata[0];
      end
    end
  end

  // ==========================================================================
  // latch capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        latch_r[i] <= 32'h00000000;
      end
      new_latch_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (latch_s2_r[i] && !latch_p_r[i] && cnt_in[i].run) begin
          latch_r[i]     <= cnt_in[i].value;
          new_latch_r[i] <= 1'b1;
        end else if (wr_outsts[i] && wdata[CLCH_OUT_LATCH_RD]) begin
          new_latch_r[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // overflow and underflow status
  // set wins over a clearing write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overflow_status_flag_r  <= '0;
      underflow_status_flag_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cnt_in[i].ovf) begin
          overflow_status_flag_r[i] <= 1'b1;
        end else if (wr_insts[i] && wdata[CLCH_IN_OVF]) begin
          overflow_status_flag_r[i] <= 1'b0;
        end
        if (cnt_in[i].unf) begin
          underflow_status_flag_r[i] <= 1'b1;
        end else if (wr_insts[i] && wdata[CLCH_IN_UNF]) begin
          underflow_status_flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // process event bits
  always_comb begin
    event_nxt = event_r;
    if (wr && !ch_hit && addr == CLCH_OFS_EVENT) begin
      event_nxt = event_r & ~wdata;
    end
    for (int i = 0; i < NDIN; i++) begin
      if (irqen_in_r && (din_s2_r[i] != din_p_r[i])) begin
        event_nxt[i] = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (cfg_r[i].en_gate && cnt_in[i].gopen) begin
        event_nxt[CLCH_EV_CNT_BASE + 4*i] = 1'b1;
      end
      if (cfg_r[i].en_gate && cnt_in[i].gclose) begin
        event_nxt[CLCH_EV_CNT_BASE + 4*i + 1] = 1'b1;
      end
      // overruns inside an active band would chatter, so they stay quiet
      if (cfg_r[i].en_ovf && !hyst_on[i] && (cnt_in[i].ovf || cnt_in[i].unf || cnt_in[i].endv)) begin
        event_nxt[CLCH_EV_CNT_BASE + 4*i + 2] = 1'b1;
      end
      if (cfg_r[i].en_cmp && reach[i]) begin
        event_nxt[CLCH_EV_CNT_BASE + 4*i + 3] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_r       <= CLCH_EVENT_RST;
      process_irq_r <= 1'b0;
    end else begin
      event_r       <= event_nxt;
      process_irq_r <= (event_r != 32'h00000000);
    end
  end

  // ==========================================================================
  // register reads
  // data stand one cycle only, zero otherwise and for unmapped addresses
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h00000000;
    end else if (!rd) begin
      rdata_r <= 32'h00000000;
    end else if (ch_hit && ch_ofs == CLCH_OFS_CFG) begin
      rdata_r <= {8'h00, cfg_r[ch_sel]};
    end else if (ch_hit && ch_ofs == CLCH_OFS_CMP) begin
      rdata_r <= cmp_r[ch_sel];
    end else if (ch_hit && ch_ofs == CLCH_OFS_OUTSTS) begin
      rdata_r <= {16'h0000, outsts_r[ch_sel]};
    end else if (ch_hit && ch_ofs == CLCH_OFS_INSTS) begin
      rdata_r <= 32'h00000000;
      rdata_r[CLCH_IN_NEW_LATCH] <= new_latch_r[ch_sel];
      rdata_r[CLCH_IN_CMP_OUT]   <= unit_out[ch_sel];
      rdata_r[CLCH_IN_HYST_ON]   <= hyst_on[ch_sel];
      rdata_r[CLCH_IN_OVF]       <= overflow_status_flag_r[ch_sel];
      rdata_r[CLCH_IN_UNF]       <= underflow_status_flag_r[ch_sel];
    end else if (ch_hit && ch_ofs == CLCH_OFS_IMAGE) begin
      if (outsts_r[ch_sel][CLCH_OUT_LATCH_RD]) begin
        rdata_r <= latch_r[ch_sel];
      end else begin
        rdata_r <= cnt_in[ch_sel].value;
      end
    end else if (!ch_hit && addr == CLCH_OFS_EVENT) begin
      rdata_r <= event_r;
    end else if (!ch_hit && addr == CLCH_OFS_IRQEN) begin
      rdata_r <= {31'h00000000, irqen_in_r};
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

endmodule : clch_top
`default_nettype wire

/* File: clch_pkg.sv */
// Purpose: shared constants and types of the latch, compare and event block
// Assumes: 40 MHz module clock, 32-bit counter values from the counter core
// Notes:   register offsets are byte addresses on the plain register port
package clch_pkg;

  // ==========================================================================
  // timing
  localparam real CLCH_CLOCK_MHZ      = 40.0;
  localparam real CLCH_PULSE_STEP_MS  = 2.048;
  localparam real CLCH_PULSE_MAX_MS   = 522.24;
  localparam int  CLCH_STEP_CYC       = int'(CLCH_PULSE_STEP_MS * 1000.0 * CLCH_CLOCK_MHZ);
  localparam int  CLCH_PULSE_MAX_STEP = int'(CLCH_PULSE_MAX_MS / CLCH_PULSE_STEP_MS);

  // ==========================================================================
  // sizes
  localparam int CLCH_NCH   = 4;
  localparam int CLCH_NDIN  = 16;
  localparam int CLCH_AW    = 8;

  // ==========================================================================
  // register map
  localparam logic [7:0] CLCH_OFS_CFG    = 8'h00;
  localparam logic [7:0] CLCH_OFS_CMP    = 8'h04;
  localparam logic [7:0] CLCH_OFS_OUTSTS = 8'h08;
  localparam logic [7:0] CLCH_OFS_INSTS  = 8'h0C;
  localparam logic [7:0] CLCH_OFS_IMAGE  = 8'h10;
  localparam logic [7:0] CLCH_OFS_EVENT  = 8'h80;
  localparam logic [7:0] CLCH_OFS_IRQEN  = 8'h84;
  localparam int         CLCH_CH_STRIDE_LSB = 5;

  // ==========================================================================
  // field positions
  localparam int CLCH_OUT_LATCH_RD = 8;
  localparam int CLCH_IN_NEW_LATCH = 15;
  localparam int CLCH_IN_CMP_OUT   = 0;
  localparam int CLCH_IN_HYST_ON   = 1;
  localparam int CLCH_IN_OVF       = 2;
  localparam int CLCH_IN_UNF       = 3;
  localparam int CLCH_EV_CNT_BASE  = 16;
  localparam int CLCH_HYST_MIN_ON  = 2;

  // ==========================================================================
  // reset values
  localparam logic [23:0] CLCH_CFG_RST    = 24'h000000;
  localparam logic [31:0] CLCH_CMP_RST    = 32'h00000000;
  localparam logic [15:0] CLCH_OUTSTS_RST = 16'h0000;
  localparam logic [31:0] CLCH_EVENT_RST  = 32'h00000000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {CLCH_NEVER, CLCH_GE, CLCH_LT, CLCH_PULSE} clch_mode_t;
  typedef enum logic [1:0] {CLCH_DIR_NONE, CLCH_DIR_FWD, CLCH_DIR_BACK, CLCH_DIR_RSV} clch_dir_t;

  typedef struct packed {
    logic [7:0] hyst;
    logic [7:0] pulse;
    logic       en_cmp;
    logic       en_ovf;
    logic       en_gate;
    logic       out_bit;
    clch_dir_t  main_dir;
    clch_mode_t mode;
  } clch_cfg_t;

  typedef struct packed {
    logic [31:0] value;
    logic        upd;
    logic        up;
    logic        run;
    logic        ovf;
    logic        unf;
    logic        endv;
    logic        gopen;
    logic        gclose;
  } clch_cnt_t;

endpackage : clch_pkg

/* File: clch_unit.sv */
// Purpose: comparator, hysteresis band and pulse timer of one counter channel
// Assumes: counter value and update strobe on the module clock
// Notes:   a nonzero pulse length is an exact multiple of the step; zero holds while equal
`timescale 1ns/1ps
`default_nettype none
module clch_unit
  import clch_pkg::*;
#(
  parameter int STEP_CYC = CLCH_STEP_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // settings
  input  wire clch_cfg_t   cfg,
  input  wire logic [31:0] cmp_val,
  // counter core
  input  wire clch_cnt_t   cnt,
  // results
  output logic             out_q,
  output logic             reach_q,
  output logic             hyst_on
);

  localparam int PW = $clog2(STEP_CYC + 1);

  logic signed [32:0] diff;
  logic signed [32:0] hwx;
  logic               in_band;
  logic               dir_ok;
  logic               cond_raw;
  logic               cond_eff;
  logic               cond_prev_r;
  logic [7:0]         hw_r;
  logic               pulsing_r;
  logic [7:0]         rem_r;
  logic [PW-1:0]      pre_r;
  logic               reach;

  // ==========================================================================
  // comparison
  assign diff    = $signed({cnt.value[31], cnt.value}) - $signed({cmp_val[31], cmp_val});
  assign hwx     = $signed({25'h0000000, hw_r});
  assign in_band = (diff <= hwx) && (diff >= -hwx);
  assign dir_ok  = (cfg.main_dir == CLCH_DIR_NONE) || (cfg.main_dir == CLCH_DIR_FWD && cnt.up) ||
                   (cfg.main_dir == CLCH_DIR_BACK && !cnt.up);

  always_comb begin
    case (cfg.mode)
      CLCH_GE:    cond_raw = !diff[32];
      CLCH_LT:    cond_raw = diff[32];
      CLCH_PULSE: cond_raw = (diff == 33'sh0) && dir_ok;
      default:    cond_raw = 1'b0;
    endcase
  end

  // frozen result while the band holds
  assign cond_eff = hyst_on ? 1'b1 : cond_raw;
  assign reach    = cnt.upd && cond_eff && !cond_prev_r;

  // ==========================================================================
  // hysteresis band
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hyst_on     <= 1'b0;
      hw_r        <= 8'h00;
      cond_prev_r <= 1'b0;
    end else if (cnt.upd) begin
      cond_prev_r <= cond_eff;
      if (hyst_on && !in_band) begin
        hyst_on <= 1'b0;
      end else if (!hyst_on && cond_raw && !cond_prev_r && cfg.hyst >= 8'(CLCH_HYST_MIN_ON)) begin
        hyst_on <= 1'b1;
        hw_r    <= cfg.hyst;
      end
    end
  end

  // ==========================================================================
  // output and pulse timer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_q     <= 1'b0;
      reach_q   <= 1'b0;
      pulsing_r <= 1'b0;
      rem_r     <= 8'h00;
      pre_r     <= '0;
    end else begin
      reach_q <= reach;
      case (cfg.mode)
        CLCH_NEVER: begin
          out_q     <= cfg.out_bit;
          pulsing_r <= 1'b0;
        end
        CLCH_GE, CLCH_LT: begin
          out_q     <= cond_eff;
          pulsing_r <= 1'b0;
        end
        default: begin
          if (!pulsing_r) begin
            out_q <= reach;
            if (reach) begin
              pulsing_r <= 1'b1;
              rem_r     <= cfg.pulse;
              pre_r     <= PW'(STEP_CYC - 1);
            end
          end else if (rem_r == 8'h00) begin
            if (cnt.upd && !cond_eff) begin
              out_q     <= 1'b0;
              pulsing_r <= 1'b0;
            end
          end else if (pre_r != '0) begin
            pre_r <= pre_r - PW'(1);
          end else if (rem_r == 8'h01) begin
            out_q     <= 1'b0;
            pulsing_r <= 1'b0;
          end else begin
            rem_r <= rem_r - 8'h01;
            pre_r <= PW'(STEP_CYC - 1);
          end
        end
      endcase
    end
  end

endmodule : clch_unit
`default_nettype wire

/* File: clch_asserts.sv */
// Purpose: port properties of the latch and compare block, channel 0
// Assumes: the bench writes settings of channel 0 only
// Notes:   settings are shadowed from the register port
`timescale 1ns/1ps
`default_nettype none
module clch_asserts
  import clch_pkg::*;
#(
  parameter int NCH      = CLCH_NCH,
  parameter int NDIN     = CLCH_NDIN,
  parameter int STEP_CYC = CLCH_STEP_CYC
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 resetn,
  // register port
  input wire logic [CLCH_AW-1:0]   addr,
  input wire logic [31:0]          wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire logic [31:0]          rdata,
  // counter core and pins
  input wire clch_cnt_t [NCH-1:0]  cnt_in,
  input wire logic [NCH-1:0]       latch_pin,
  input wire logic [NDIN-1:0]      din_pin,
  // outputs
  input wire logic [NCH-1:0]       cmp_out,
  input wire logic                 process_irq
);
  // ==========================================================================
  // shadow state
  clch_cfg_t   cfg_r;
  clch_mode_t  mode_d_r;
  logic [31:0] cmp_r;
  logic [31:0] hi_cnt_r;
  logic        ge_d_r;
  logic        eq_d_r;
  logic        up_d_r;
  logic        outb_d_r;
  logic        hyst_seen_r;
  logic        en_seen_r;
  wire         hyst_gate = hyst_seen_r || (cfg_r.hyst >= 8'h02);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= '0;
      cmp_r <= '0;
    end else if (wr && addr == CLCH_OFS_CFG) begin
      cfg_r <= clch_cfg_t'(wdata[23:0]);
    end else if (wr && addr == CLCH_OFS_CMP) begin
      cmp_r <= wdata;
    end
  end

  // sticky flags: a band or an enable, once seen, voids the simple checks
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hyst_seen_r <= 1'b0;
      en_seen_r   <= 1'b0;
    end else begin
      hyst_seen_r <= hyst_gate;
      en_seen_r   <= en_seen_r || (wr && ((addr == CLCH_OFS_CFG && wdata[7:5] != 3'h0)
                                        || (addr == CLCH_OFS_IRQEN && wdata[0])));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_r <= '0;
      mode_d_r <= CLCH_NEVER;
      ge_d_r   <= 1'b0;
      eq_d_r   <= 1'b0;
      up_d_r   <= 1'b0;
      outb_d_r <= 1'b0;
    end else begin
      hi_cnt_r <= cmp_out[0] ? hi_cnt_r + 32'h1 : 32'h0;
      mode_d_r <= cfg_r.mode;
      ge_d_r   <= $signed(cnt_in[0].value) >= $signed(cmp_r);
      eq_d_r   <= cnt_in[0].value == cmp_r;
      up_d_r   <= cnt_in[0].up;
      outb_d_r <= cfg_r.out_bit;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // properties
  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  property p_never;
    cfg_r.mode == CLCH_NEVER && mode_d_r == CLCH_NEVER |-> cmp_out[0] == outb_d_r;
  endproperty
  property p_ge;
    cfg_r.mode == CLCH_GE && mode_d_r == CLCH_GE && !hyst_gate |-> cmp_out[0] == ge_d_r;
  endproperty
  property p_lt;
    cfg_r.mode == CLCH_LT && mode_d_r == CLCH_LT && !hyst_gate |-> cmp_out[0] == !ge_d_r;
  endproperty
  property p_pulse_len;
    $fell(cmp_out[0]) && cfg_r.mode == CLCH_PULSE && cfg_r.pulse != 8'h00
      |-> hi_cnt_r == cfg_r.pulse * STEP_CYC;
  endproperty
  property p_pulse0;
    $fell(cmp_out[0]) && cfg_r.mode == CLCH_PULSE && cfg_r.pulse == 8'h00 && !hyst_gate |-> !eq_d_r;
  endproperty
  property p_dir;
    $rose(cmp_out[0]) && cfg_r.mode == CLCH_PULSE && cfg_r.main_dir != CLCH_DIR_NONE
      |-> up_d_r == (cfg_r.main_dir == CLCH_DIR_FWD);
  endproperty
  property p_irq_quiet;
    !en_seen_r |-> !process_irq;
  endproperty

  a_rd_idle:    assert property (p_rd_idle) else $error("read data outside read slot");
  a_never:      assert property (p_never) else $error("never mode output wrong");
  a_ge:         assert property (p_ge) else $error("ge mode output wrong");
  a_lt:         assert property (p_lt) else $error("lt mode output wrong");
  a_pulse_len:  assert property (p_pulse_len) else $error("pulse length wrong");
  a_pulse0:     assert property (p_pulse0) else $error("zero pulse ended early");
  a_dir:        assert property (p_dir) else $error("pulse from wrong direction");
  a_irq_quiet:  assert property (p_irq_quiet) else $error("interrupt without enable");

  c_pulse: cover property ($rose(cmp_out[0]) && cfg_r.mode == CLCH_PULSE);
  c_ge:    cover property (cfg_r.mode == CLCH_GE && $rose(cmp_out[0]));
  c_irq:   cover property ($rose(process_irq));
endmodule : clch_asserts

bind clch_top clch_asserts #(.NCH(NCH), .NDIN(NDIN), .STEP_CYC(STEP_CYC)) u_chk (
  .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cnt_in(cnt_in), .latch_pin(latch_pin), .din_pin(din_pin), .cmp_out(cmp_out),
  .process_irq(process_irq)
);
`default_nettype wire

/* File: clch_cnt_model.sv */
// Purpose: counter core stand-in driving channel 0
// Assumes: bench commands load and single steps
// Notes:   other channels stay idle at zero
`timescale 1ns/1ps
`default_nettype none
module clch_cnt_model
  import clch_pkg::*;
#(
  parameter int NCH = CLCH_NCH
) (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           resetn,
  // bench commands
  input  wire logic           ld,
  input  wire logic [31:0]    ld_val,
  input  wire logic           step,
  input  wire logic           up_dir,
  input  wire logic           run,
  // counter core
  output var clch_cnt_t [NCH-1:0] cnt
);
  logic [31:0] v_r;
  logic        upd_r;
  logic        ovf_r;
  logic        unf_r;
  logic        run_r;
  logic        gopen_r;
  logic        gclose_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      v_r      <= '0;
      upd_r    <= 1'b0;
      ovf_r    <= 1'b0;
      unf_r    <= 1'b0;
      run_r    <= 1'b0;
      gopen_r  <= 1'b0;
      gclose_r <= 1'b0;
    end else begin
      upd_r    <= ld || step;
      ovf_r    <= step && up_dir && v_r == 32'h7FFFFFFF;
      unf_r    <= step && !up_dir && v_r == 32'h80000000;
      run_r    <= run;
      gopen_r  <= run && !run_r;
      gclose_r <= !run && run_r;
      if (ld) begin
        v_r <= ld_val;
      end else if (step) begin
        v_r <= up_dir ? v_r + 32'h1 : v_r - 32'h1;
      end
    end
  end

  always_comb begin
    cnt    = '0;
    cnt[0] = '{value: v_r, upd: upd_r, up: up_dir, run: run_r, ovf: ovf_r, unf: unf_r,
               endv: 1'b0, gopen: gopen_r, gclose: gclose_r};
  end
endmodule : clch_cnt_model
`default_nettype wire

/* File: clch_tb.sv */
// Purpose: directed register-level tests of the latch and compare block
// Assumes: short pulse step so timed pulses stay brief
// Notes:   channel 0 only; the counter model stands in for the core
`timescale 1ns/1ps
`default_nettype none
module tb
  import clch_pkg::*;
;
  localparam int STEP = 4;
  localparam logic [31:0] VALS [5] = '{32'h9, 32'hA, 32'hFFFFFFFB, 32'h9, 32'hA};
  localparam logic [1:0]  MDS  [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic        EXPS [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic              clock, resetn, wr, rd, ld, step, up_dir, run, process_irq;
  logic [7:0]        addr;
  logic [31:0]       wdata, ld_val, rdata, d;
  logic [3:0]        latch_pin, cmp_out;
  logic [15:0]       din_pin;
  clch_cnt_t [3:0]   cnt_in;
  int                error_cnt, check_count, cyc, n, k;

  clch_cnt_model u_cnt (.clock(clock), .resetn(resetn), .ld(ld), .ld_val(ld_val), .step(step),
    .up_dir(up_dir), .run(run), .cnt(cnt_in));
  clch_top #(.STEP_CYC(STEP)) dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cnt_in(cnt_in), .latch_pin(latch_pin), .din_pin(din_pin),
    .cmp_out(cmp_out), .process_irq(process_irq));

  // ==========================================================================
  // tasks
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic chk_out(input logic e);
    check("cmp_out", {31'h0, e}, {31'h0, cmp_out[0]});
  endtask : chk_out
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clock) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock) begin addr <= a; rd <= 1'b1; end
    @(posedge clock) rd <= 1'b0;
    @(negedge clock) v = rdata;
  endtask : rd_reg
  task automatic ld_cnt(input logic [31:0] v);
    @(posedge clock) begin ld <= 1'b1; ld_val <= v; end
    @(posedge clock) ld <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : ld_cnt
  task automatic stp(input logic u);
    @(posedge clock) begin step <= 1'b1; up_dir <= u; end
    @(posedge clock) step <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : stp
  task automatic pulse_latch();
    @(posedge clock) latch_pin <= 4'h1;
    repeat (3) @(posedge clock);
    latch_pin <= 4'h0;
    repeat (6) @(posedge clock);
  endtask : pulse_latch

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    {resetn, wr, rd, ld, step, up_dir, run} = '0;
    {addr, wdata, ld_val, latch_pin, din_pin} = '0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd_reg(CLCH_OFS_CFG, d); check("cfg_rst", 32'h0, d);
    wr_reg(8'h14, 32'hFFFFFFFF); rd_reg(8'h14, d); check("unmapped", 32'h0, d);
    wr_reg(CLCH_OFS_CFG, 32'h0000FF10); rd_reg(CLCH_OFS_CFG, d); check("cfg", 32'h0000FF10, d);
    ld_cnt(32'h5); chk_out(1'b1);
    wr_reg(CLCH_OFS_CMP, 32'hA);
    for (int i = 0; i < 5; i++) begin
      wr_reg(CLCH_OFS_CFG, {30'h0, MDS[i]});
      ld_cnt(VALS[i]);
      chk_out(EXPS[i]);
    end
    wr_reg(CLCH_OFS_CFG, 32'h0);
    @(posedge clock) run <= 1'b1;
    ld_cnt(32'h4D2); pulse_latch();
    rd_reg(CLCH_OFS_INSTS, d); check("new_latch", 32'h8000, d & 32'h8000);
    wr_reg(CLCH_OFS_OUTSTS, 32'h100); rd_reg(CLCH_OFS_IMAGE, d); check("image", 32'h4D2, d);
    rd_reg(CLCH_OFS_INSTS, d); check("new_latch", 32'h0, d & 32'h8000);
    @(posedge clock) run <= 1'b0;
    ld_cnt(32'h37); pulse_latch();
    rd_reg(CLCH_OFS_IMAGE, d); check("image", 32'h4D2, d);
    wr_reg(CLCH_OFS_IRQEN, 32'h1);
    @(posedge clock) din_pin <= 16'h0008;
    repeat (6) @(posedge clock);
    rd_reg(CLCH_OFS_EVENT, d); check("event", 32'h8, d);
    check("irq", 32'h1, {31'h0, process_irq});
    wr_reg(CLCH_OFS_EVENT, 32'h8); rd_reg(CLCH_OFS_EVENT, d); check("event", 32'h0, d);
    check("irq", 32'h0, {31'h0, process_irq});
    wr_reg(CLCH_OFS_CFG, 32'h40); ld_cnt(32'h7FFFFFFF); stp(1'b1);
    rd_reg(CLCH_OFS_INSTS, d); check("ovf", 32'h4, d & 32'h4);
    rd_reg(CLCH_OFS_EVENT, d); check("event", 32'h40000, d);
    wr_reg(CLCH_OFS_INSTS, 32'h4); wr_reg(CLCH_OFS_EVENT, 32'hFFFFFFFF);
    // timed pulse re-reached mid pulse
    wr_reg(CLCH_OFS_CMP, 32'h14); wr_reg(CLCH_OFS_CFG, 32'h283); ld_cnt(32'h13);
    @(posedge clock) begin step <= 1'b1; up_dir <= 1'b1; end
    @(posedge clock) step <= 1'b0;
    while (cmp_out[0] !== 1'b1 && k < 20) begin @(posedge clock); #1; k++; end
    while (cmp_out[0] === 1'b1 && n < 99) begin
      @(posedge clock) begin step <= (n == 1) || (n == 3); up_dir <= (n >= 3); end
      #1;
      n++;
    end
    check("pulse_len", 32'(2 * STEP), 32'(n));
    rd_reg(CLCH_OFS_EVENT, d); check("event", 32'h80000, d);
    check("irq", 32'h1, {31'h0, process_irq});
    wr_reg(CLCH_OFS_EVENT, 32'hFFFFFFFF);
    wr_reg(CLCH_OFS_CFG, 32'h20B); ld_cnt(32'h13); stp(1'b1); chk_out(1'b0);
    ld_cnt(32'h15); stp(1'b0); chk_out(1'b1);
    repeat (10) @(posedge clock);
    // zero duration holds while equal
    ld_cnt(32'h13); wr_reg(CLCH_OFS_CFG, 32'h3); stp(1'b1);
    repeat (20) @(posedge clock);
    @(negedge clock) chk_out(1'b1);
    stp(1'b1); chk_out(1'b0);
    // hysteresis band of 3 around 20
    wr_reg(CLCH_OFS_CFG, 32'h00030001); ld_cnt(32'h13); stp(1'b1);
    rd_reg(CLCH_OFS_INSTS, d); check("hyst", 32'h3, d & 32'h3);
    for (int i = 0; i < 3; i++) begin stp(1'b0); chk_out(1'b1); end
    stp(1'b0); chk_out(1'b0);
    ld_cnt(32'h13); stp(1'b1); wr_reg(CLCH_OFS_CFG, 32'h1); stp(1'b0); chk_out(1'b1);
    wr_reg(CLCH_OFS_CFG, 32'h10001); ld_cnt(32'h0); ld_cnt(32'h13); stp(1'b1); stp(1'b0); chk_out(1'b0);
    wr_reg(CLCH_OFS_CFG, 32'h00FF0000); rd_reg(CLCH_OFS_CFG, d); check("cfg", 32'h00FF0000, d);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
